// ===== core/monitor_adc_pkg.sv
package monitor_adc_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CHIPSET_VALUE = 8'h21;
    localparam logic [7:0] ADDR_MAIN_VALUE = 8'h22;
    localparam logic [7:0] ADDR_TEMP_FIRST = 8'h25;
    localparam logic [7:0] ADDR_TEMP_SECOND = 8'h26;
    localparam logic [7:0] ADDR_TEMP_THIRD = 8'h27;
    localparam logic [7:0] ADDR_CHAN_SELECT = 8'h55;
    localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;
    localparam logic [7:0] ADDR_FRACTION_ONE = 8'h76;
    localparam logic [7:0] ADDR_FRACTION_TWO = 8'h77;

    // Field positions.
    localparam int CFG2_AVG_OFF_BIT = 4;
    localparam int CFG2_BYPASS_BIT = 5;
    localparam int CFG2_SINGLE_BIT = 6;
    localparam int CHAN_SELECT_LSB = 5;
    localparam int FRAC_REMOTE_TWO_LSB = 6;
    localparam int FRAC_LOCAL_LSB = 4;
    localparam int FRAC_REMOTE_ONE_LSB = 2;
    localparam int FRAC_MAIN_LSB = 2;
    localparam int FRAC_CHIPSET_LSB = 0;

    // Reset values.
    localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;
    localparam logic [7:0] CHAN_SELECT_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // Averaging.
    localparam int AVG_SAMPLES = 16;
    localparam logic [4:0] AVG_COUNT_FULL = 5'h10;
    localparam logic [4:0] AVG_COUNT_ONE = 5'h01;

    // Temperature offset format: 64 degrees in quarter-degree steps.
    localparam int TEMP_OFFSET_DEG = 64;
    localparam int QUARTERS_PER_DEG = 4;
    localparam logic signed [10:0] TEMP_OFFSET_CODE = 11'(TEMP_OFFSET_DEG * QUARTERS_PER_DEG);

    // Timing.
    localparam int CLK_PERIOD_NS = 5;
    localparam int VOLT_CONV_NS = 711000;
    localparam int REMOTE_MEAS_NS = 38000000;
    localparam int VOLT_CONV_CYCLES = VOLT_CONV_NS / CLK_PERIOD_NS;
    localparam int REMOTE_MEAS_CYCLES = REMOTE_MEAS_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 24;

    // Converter channel codes.
    typedef enum logic [2:0] {
        CH_CHIPSET = 3'h1,
        CH_MAIN = 3'h2,
        CH_REMOTE1 = 3'h5,
        CH_LOCAL = 3'h6,
        CH_REMOTE2 = 3'h7
    } chan_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        SEQ_START = 2'h0,
        SEQ_WAIT = 2'h1,
        SEQ_PACE = 2'h2,
        SEQ_COMMIT = 2'h3
    } seq_state_t;

    // Register access request from the management bus front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Control towards the converter and its multiplexer.
    typedef struct packed {
        logic start;
        logic [2:0] chan;
        logic bypass;
    } adc_ctrl_t;

    // True for the two diode channels.
    function automatic logic is_remote(input chan_t ch);
        is_remote = (ch == CH_REMOTE1) || (ch == CH_REMOTE2);
    endfunction : is_remote

    // Round-robin successor.
    function automatic chan_t next_channel(input chan_t ch);
        case (ch)
            CH_CHIPSET: next_channel = CH_MAIN;
            CH_MAIN: next_channel = CH_REMOTE1;
            CH_REMOTE1: next_channel = CH_LOCAL;
            CH_LOCAL: next_channel = CH_REMOTE2;
            default: next_channel = CH_CHIPSET;
        endcase
    endfunction : next_channel

    // Single-channel select decode; unused codes fall back to the chipset supply.
    function automatic chan_t decode_select(input logic [2:0] sel);
        case (sel)
            3'h1: decode_select = CH_CHIPSET;
            3'h2: decode_select = CH_MAIN;
            3'h5: decode_select = CH_REMOTE1;
            3'h6: decode_select = CH_LOCAL;
            3'h7: decode_select = CH_REMOTE2;
            default: decode_select = CH_CHIPSET;
        endcase
    endfunction : decode_select

    // Twos complement code kept as is, or shifted by 64 degrees and clamped at zero.
    function automatic logic [9:0] format_temp(input logic [9:0] code, input logic twos);
        logic signed [10:0] shifted;
        shifted = $signed({code[9], code}) + TEMP_OFFSET_CODE;
        if (twos) begin
            format_temp = code;
        end else if (shifted < 0) begin
            format_temp = 10'h000;
        end else begin
            format_temp = shifted[9:0];
        end
    endfunction : format_temp

endpackage : monitor_adc_pkg

// ===== core/sample_averager.sv
`timescale 1ns/1ps
module sample_averager import monitor_adc_pkg::*; (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Sample input.
    input wire logic i_clear,
    input wire logic i_add,
    input wire logic [9:0] i_code,
    input wire logic i_single,
    // Accumulated result.
    output logic [4:0] o_count,
    output logic [9:0] o_avg
);

    logic [13:0] sum_q;
    logic [13:0] sum_d;
    logic [4:0] count_q;
    logic [4:0] count_d;

    // Clear wins over add; the sequencer never asks for both at once.
    always_comb begin
        sum_d = sum_q;
        count_d = count_q;
        if (i_clear) begin
            sum_d = 14'h0000;
            count_d = 5'h00;
        end else if (i_add) begin
            sum_d = sum_q + {4'h0, i_code};
            count_d = count_q + 5'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sum_q <= 14'h0000;
            count_q <= 5'h00;
        end else begin
            sum_q <= sum_d;
            count_q <= count_d;
        end
    end

    // Sixteen samples divide by a shift, so the mean never exceeds 1023.
    assign o_count = count_q;
    assign o_avg = i_single ? sum_q[9:0] : sum_q[13:4];

endmodule : sample_averager

// ===== core/monitor_adc_sequencer.sv
`timescale 1ns/1ps
module monitor_adc_sequencer import monitor_adc_pkg::*; #(
    parameter int P_VOLT_CONV_CYCLES = VOLT_CONV_CYCLES,
    parameter int P_REMOTE_MEAS_CYCLES = REMOTE_MEAS_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Register access from the management bus front end.
    input wire reg_req_t i_reg,
    output logic [7:0] o_reg_rdata,
    // Converter control and result.
    output adc_ctrl_t o_adc,
    input wire logic i_adc_done,
    input wire logic [9:0] i_adc_code,
    // Temperature format: high for twos complement, low for offset 64.
    input wire logic i_temp_twos_fmt
);

    localparam logic [TIMER_W-1:0] VOLT_SLOT_LAST = TIMER_W'(P_VOLT_CONV_CYCLES - 1);
    localparam logic [TIMER_W-1:0] REMOTE_SLOT_LAST =
        TIMER_W'(P_REMOTE_MEAS_CYCLES / AVG_SAMPLES - 1);

    seq_state_t state_q;
    seq_state_t state_d;
    chan_t chan_q;
    chan_t chan_d;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] timer_d;
    logic avg_off_q;
    logic avg_off_d;
    logic avg_clear;
    logic avg_add;
    logic [4:0] avg_count;
    logic [9:0] avg_code;
    logic [4:0] need_count;
    logic [9:0] temp_code;
    logic [7:0] cfg2_q;
    logic [7:0] cfg2_d;
    logic [7:0] chansel_q;
    logic [7:0] chansel_d;
    logic [2:0][7:0] temp_val_q;
    logic [2:0][7:0] temp_val_d;
    logic [1:0][7:0] volt_val_q;
    logic [1:0][7:0] volt_val_d;
    logic [7:0] frac_two_q;
    logic [7:0] frac_two_d;
    logic [7:0] frac_one_q;
    logic [7:0] frac_one_d;
    logic temp_frz_q;
    logic temp_frz_d;
    logic volt_frz_q;
    logic volt_frz_d;
    logic [2:0][7:0] temp_snap_q;
    logic [2:0][7:0] temp_snap_d;
    logic [1:0][7:0] volt_snap_q;
    logic [1:0][7:0] volt_snap_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rd_temp_val;
    logic rd_volt_val;

    // Remote channels always average; voltage and local obey the averaging-off bit.
    assign need_count = (avg_off_q && !is_remote(chan_q)) ? AVG_COUNT_ONE : AVG_COUNT_FULL;
    assign temp_code = format_temp(avg_code, i_temp_twos_fmt);

    sample_averager u_averager (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(avg_clear),
        .i_add(avg_add),
        .i_code(i_adc_code),
        .i_single(need_count == AVG_COUNT_ONE),
        .o_count(avg_count),
        .o_avg(avg_code)
    );

    // Converter control; the bypass level follows the configuration at once.
    assign o_adc.start = (state_q == SEQ_START);
    assign o_adc.chan = chan_q;
    assign o_adc.bypass = cfg2_q[CFG2_BYPASS_BIT];

    // Sequencer: start, wait for the code, hold the slot time, commit after the last sample.
    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        timer_d = timer_q;
        avg_off_d = avg_off_q;
        avg_clear = 1'b0;
        avg_add = 1'b0;
        case (state_q)
            SEQ_START: begin
                timer_d = is_remote(chan_q) ? REMOTE_SLOT_LAST : VOLT_SLOT_LAST;
                if (avg_count == 5'h00) begin
                    avg_off_d = cfg2_q[CFG2_AVG_OFF_BIT];
                end
                state_d = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (timer_q != '0) begin
                    timer_d = timer_q - 1'b1;
                end
                if (i_adc_done) begin
                    avg_add = 1'b1;
                    state_d = SEQ_PACE;
                end
            end
            SEQ_PACE: begin
                if (timer_q != '0) begin
                    timer_d = timer_q - 1'b1;
                end else if (avg_count == need_count) begin
                    state_d = SEQ_COMMIT;
                end else begin
                    state_d = SEQ_START;
                end
            end
            SEQ_COMMIT: begin
                avg_clear = 1'b1;
                if (cfg2_q[CFG2_SINGLE_BIT]) begin
                    chan_d = decode_select(chansel_q[CHAN_SELECT_LSB +: 3]);
                end else begin
                    chan_d = next_channel(chan_q);
                end
                state_d = SEQ_START;
            end
            default: begin
                state_d = SEQ_START;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= SEQ_START;
            chan_q <= CH_CHIPSET;
            timer_q <= '0;
            avg_off_q <= 1'b0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            timer_q <= timer_d;
            avg_off_q <= avg_off_d;
        end
    end

    // Result store, written only in the commit cycle.
    always_comb begin
        temp_val_d = temp_val_q;
        volt_val_d = volt_val_q;
        frac_two_d = frac_two_q;
        frac_one_d = frac_one_q;
        if (state_q == SEQ_COMMIT) begin
            case (chan_q)
                CH_CHIPSET: begin
                    volt_val_d[0] = avg_code[9:2];
                    frac_one_d[FRAC_CHIPSET_LSB +: 2] = avg_code[1:0];
                end
                CH_MAIN: begin
                    volt_val_d[1] = avg_code[9:2];
                    frac_one_d[FRAC_MAIN_LSB +: 2] = avg_code[1:0];
                end
                CH_REMOTE1: begin
                    temp_val_d[0] = temp_code[9:2];
                    frac_two_d[FRAC_REMOTE_ONE_LSB +: 2] = temp_code[1:0];
                end
                CH_LOCAL: begin
                    temp_val_d[1] = temp_code[9:2];
                    frac_two_d[FRAC_LOCAL_LSB +: 2] = temp_code[1:0];
                end
                CH_REMOTE2: begin
                    temp_val_d[2] = temp_code[9:2];
                    frac_two_d[FRAC_REMOTE_TWO_LSB +: 2] = temp_code[1:0];
                end
                default: begin
                    temp_val_d = temp_val_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            temp_val_q <= '0;
            volt_val_q <= '0;
            frac_two_q <= RESULT_RESET;
            frac_one_q <= RESULT_RESET;
        end else begin
            temp_val_q <= temp_val_d;
            volt_val_q <= volt_val_d;
            frac_two_q <= frac_two_d;
            frac_one_q <= frac_one_d;
        end
    end

    assign rd_temp_val = i_reg.rd && (i_reg.addr >= ADDR_TEMP_FIRST)
        && (i_reg.addr <= ADDR_TEMP_THIRD);
    assign rd_volt_val = i_reg.rd && ((i_reg.addr == ADDR_CHIPSET_VALUE)
        || (i_reg.addr == ADDR_MAIN_VALUE));

    // Registers, freeze and read data. A frozen value register answers from a snapshot
    // taken with the fraction read, so the first value read of the group after it belongs to the same measurement as the fraction.
    always_comb begin
        cfg2_d = cfg2_q;
        chansel_d = chansel_q;
        temp_frz_d = temp_frz_q;
        volt_frz_d = volt_frz_q;
        temp_snap_d = temp_snap_q;
        volt_snap_d = volt_snap_q;
        rdata_d = rdata_q;
        if (i_reg.wr && (i_reg.addr == ADDR_CONFIG_TWO)) begin
            cfg2_d = i_reg.wdata;
        end
        if (i_reg.wr && (i_reg.addr == ADDR_CHAN_SELECT)) begin
            chansel_d = i_reg.wdata;
        end
        if (rd_temp_val) begin
            temp_frz_d = 1'b0;
        end
        if (rd_volt_val) begin
            volt_frz_d = 1'b0;
        end
        if (i_reg.rd) begin
            case (i_reg.addr)
                ADDR_CHIPSET_VALUE: rdata_d = volt_frz_q ? volt_snap_q[0] : volt_val_q[0];
                ADDR_MAIN_VALUE: rdata_d = volt_frz_q ? volt_snap_q[1] : volt_val_q[1];
                ADDR_TEMP_FIRST: rdata_d = temp_frz_q ? temp_snap_q[0] : temp_val_q[0];
                ADDR_TEMP_SECOND: rdata_d = temp_frz_q ? temp_snap_q[1] : temp_val_q[1];
                ADDR_TEMP_THIRD: rdata_d = temp_frz_q ? temp_snap_q[2] : temp_val_q[2];
                ADDR_CHAN_SELECT: rdata_d = chansel_q;
                ADDR_CONFIG_TWO: rdata_d = cfg2_q;
                ADDR_FRACTION_ONE: begin
                    rdata_d = frac_one_q;
                    volt_frz_d = 1'b1;
                    volt_snap_d = volt_val_q;
                end
                ADDR_FRACTION_TWO: begin
                    rdata_d = frac_two_q;
                    temp_frz_d = 1'b1;
                    temp_snap_d = temp_val_q;
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg2_q <= CONFIG_TWO_RESET;
            chansel_q <= CHAN_SELECT_RESET;
            temp_frz_q <= 1'b0;
            volt_frz_q <= 1'b0;
            temp_snap_q <= '0;
            volt_snap_q <= '0;
            rdata_q <= 8'h00;
        end else begin
            cfg2_q <= cfg2_d;
            chansel_q <= chansel_d;
            temp_frz_q <= temp_frz_d;
            volt_frz_q <= volt_frz_d;
            temp_snap_q <= temp_snap_d;
            volt_snap_q <= volt_snap_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata = rdata_q;

    // Helper state read only by the checks below.
    logic [9:0] last_code_q;
    logic [4:0] dones_q;
    logic [TIMER_W-1:0] gap_q;
    logic seen_start_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            last_code_q <= 10'h000;
            dones_q <= 5'h00;
            gap_q <= '0;
            seen_start_q <= 1'b0;
        end else begin
            if (i_adc_done && (state_q == SEQ_WAIT)) begin
                last_code_q <= i_adc_code;
            end
            if (state_q == SEQ_COMMIT) begin
                dones_q <= 5'h00;
            end else if (i_adc_done && (state_q == SEQ_WAIT)) begin
                dones_q <= dones_q + 5'h01;
            end
            if (o_adc.start) begin
                gap_q <= {{(TIMER_W-1){1'b0}}, 1'b1};
                seen_start_q <= 1'b1;
            end else if (gap_q != '1) begin
                gap_q <= gap_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_avg_off_direct: assert property ((state_q == SEQ_COMMIT) && avg_off_q
        && !is_remote(chan_q) |-> avg_code == last_code_q)
        else $error("single conversion not stored directly");
    a_bypass_write: assert property (i_reg.wr && (i_reg.addr == ADDR_CONFIG_TWO)
        |=> o_adc.bypass == $past(i_reg.wdata[CFG2_BYPASS_BIT]))
        else $error("bypass does not follow configuration write");
    a_single_select: assert property ((state_q == SEQ_COMMIT) && cfg2_q[CFG2_SINGLE_BIT]
        |=> o_adc.chan == (($past(chansel_q[7:5]) inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7})
        ? $past(chansel_q[7:5]) : 3'h1))
        else $error("single channel mode picked wrong channel");
    a_channel_legal: assert property (o_adc.start |-> o_adc.chan inside {3'h1, 3'h2, 3'h5,
        3'h6, 3'h7})
        else $error("illegal converter channel");
    a_remote_sixteen: assert property ((state_q == SEQ_COMMIT) && is_remote(chan_q)
        |-> dones_q == AVG_COUNT_FULL)
        else $error("remote result not from sixteen samples");
    a_slot_spacing: assert property (o_adc.start && seen_start_q
        |-> gap_q > VOLT_SLOT_LAST)
        else $error("conversion started before slot time elapsed");
    a_freeze_held: assert property (temp_frz_q && !rd_temp_val |=> temp_frz_q)
        else $error("temperature freeze released without value read");
    a_fraction_layout: assert property ((state_q == SEQ_COMMIT) && (chan_q == CH_REMOTE2)
        |=> frac_two_q[7:6] == $past(temp_code[1:0]) && temp_val_q[2] == $past(temp_code[9:2]))
        else $error("remote two result misplaced");
    a_offset_format: assert property ((state_q == SEQ_COMMIT) && (chan_q == CH_LOCAL)
        && !i_temp_twos_fmt && (avg_code == 10'h000) |=> temp_val_q[1] == 8'h40)
        else $error("offset format zero degrees wrong");
    a_commit_only: assert property ($changed(temp_val_q) || $changed(volt_val_q)
        |-> $past(state_q) == SEQ_COMMIT)
        else $error("result changed outside commit");

    c_remote_commit: cover property ((state_q == SEQ_COMMIT) && (chan_q == CH_REMOTE1));
    c_single_mode: cover property ((state_q == SEQ_COMMIT) && cfg2_q[CFG2_SINGLE_BIT]);
    c_avg_off: cover property ((state_q == SEQ_COMMIT) && avg_off_q && (chan_q == CH_MAIN));
    c_freeze_read: cover property (temp_frz_q && rd_temp_val);

endmodule : monitor_adc_sequencer

// ===== testbench/adc_model.sv
`timescale 1ns/1ps
module adc_model import monitor_adc_pkg::*; (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Start request, codes by channel and answer delay.
    input wire adc_ctrl_t i_adc,
    input wire logic [7:0][9:0] i_codes,
    input wire logic [7:0] i_delay,
    // Converter answer.
    output logic o_done,
    output logic [9:0] o_code
);
    logic busy_q;
    logic [7:0] cnt_q;
    logic [2:0] chan_q;
    // The code toggles between answers, so a stale sample never passes as valid.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            chan_q <= 3'h0;
            o_done <= 1'b0;
            o_code <= 10'h000;
        end else if (i_adc.start) begin
            busy_q <= 1'b1;
            cnt_q <= i_delay;
            chan_q <= i_adc.chan;
            o_done <= 1'b0;
            o_code <= ~o_code;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            o_done <= 1'b1;
            o_code <= i_codes[chan_q];
        end else begin
            cnt_q <= cnt_q - 8'h01;
            o_done <= 1'b0;
            o_code <= ~o_code;
        end
    end
endmodule : adc_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench import monitor_adc_pkg::*;;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    localparam int VC = 20;
    localparam int RC = 320;
    logic i_clk, i_rst, done, twos;
    logic [9:0] code;
    logic [7:0] delay, rdata, v;
    logic [7:0][9:0] codes;
    logic [2:0] last_chan;
    reg_req_t req;
    adc_ctrl_t adc;
    int failures, n_checks, cyc, gap, last_start, n_starts, k;
    logic [2:0] order [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    logic [7:0] rst_addr [4] = '{8'h73, 8'h55, 8'h25, 8'h77};
    row_t rows [12] = '{'{0, 8'h77, 0, 8'h18}, '{0, 8'h25, 0, 8'h19}, '{0, 8'h26, 0, 8'h0A},
        '{0, 8'h27, 0, 8'hE7}, '{0, 8'h76, 0, 8'h03}, '{0, 8'h21, 0, 8'hFF},
        '{0, 8'h22, 0, 8'hC0}, '{1, 8'h25, 8'hFF, 0}, '{0, 8'h25, 0, 8'h19},
        '{1, 8'h55, 8'hA0, 0}, '{0, 8'h55, 0, 8'hA0}, '{0, 8'h10, 0, 8'h00}};

    monitor_adc_sequencer #(.P_VOLT_CONV_CYCLES(VC), .P_REMOTE_MEAS_CYCLES(RC))
        u_monitor_adc_sequencer (.i_clk(i_clk), .i_rst(i_rst), .i_reg(req), .o_reg_rdata(rdata),
        .o_adc(adc), .i_adc_done(done), .i_adc_code(code), .i_temp_twos_fmt(twos));
    adc_model u_adc_model (.i_clk(i_clk), .i_rst(i_rst), .i_adc(adc), .i_codes(codes),
        .i_delay(delay), .o_done(done), .o_code(code));

    // Free-running clock at 200 MHz.
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Start spacing and channel are logged here; the cycle ceiling cuts a hang short.
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (!i_rst && adc.start === 1'b1) begin
            gap <= cyc - last_start;
            last_start <= cyc;
            last_chan <= adc.chan;
            n_starts <= n_starts + 1;
        end
        if (cyc == 60000) begin
            failures++;
            summarize();
        end
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t register got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_ctl(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t control got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_ctl

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        req <= '0;
    endtask : wr

    // Read data is registered, so it is taken one cycle after the request edge.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        req <= '0;
        #1;
        chk_reg(rdata, e);
    endtask : rd_chk

    task automatic wait_start();
        int n0;
        int t;
        n0 = n_starts;
        t = 0;
        while (n_starts == n0 && t < 1000) begin
            @(posedge i_clk);
            #1;
            t++;
        end
    endtask : wait_start

    // Two commits are passed, since a write just before a commit may miss it.
    task automatic sync();
        for (int j = 0; j < 2; j++) begin
            wait_start();
            for (int m = 0; m < 40 && gap != VC + 2; m++) wait_start();
        end
    endtask : sync

    task automatic gaps(input int n, input int slot);
        for (int i = 0; i < n; i++) begin
            wait_start();
            chk_ctl(10'(gap), 10'(i == n - 1 ? slot + 2 : slot + 1));
        end
    endtask : gaps

    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    // Main sequence: table rows first, then the awkward cases and a second reset.
    initial begin
        req = '0;
        i_rst = 1'b1;
        twos = 1'b1;
        delay = 8'h03;
        codes = '0;
        codes[1] = 10'h3FF;
        codes[2] = 10'h300;
        codes[5] = 10'h066;
        codes[6] = 10'h029;
        codes[7] = 10'h39C;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3600) @(posedge i_clk);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else rd_chk(rows[i].a, rows[i].e);
        end
        $display("test rows done");
        @(posedge i_clk);
        twos <= 1'b0;
        repeat (3600) @(posedge i_clk);
        rd_chk(8'h77, 8'h18);
        rd_chk(8'h25, 8'h59);
        rd_chk(8'h27, 8'h27);
        rd_chk(8'h77, 8'h18);
        @(posedge i_clk);
        codes[5] <= 10'h0C8;
        codes[6] <= 10'h000;
        delay <= 8'h0F;
        repeat (3600) @(posedge i_clk);
        rd_chk(8'h25, 8'h59);
        rd_chk(8'h25, 8'h72);
        rd_chk(8'h26, 8'h40);
        $display("test format and freeze done");
        wr(8'h73, 8'h20);
        @(posedge i_clk);
        #1;
        chk_ctl({9'h000, adc.bypass}, 10'h001);
        sync();
        k = 0;
        while (order[k] !== last_chan && k < 4) k++;
        for (int i = 0; i < 4; i++) begin
            sync();
            // Each sync passes two commits, so the channel moves on by two places.
            k = (k + 2) % 5;
            chk_ctl(10'(last_chan), 10'(order[k]));
        end
        $display("test round robin done");
        wr(8'h73, 8'h50);
        foreach (order[i]) begin
            wr(8'h55, {order[i], 5'h00});
            sync();
            chk_ctl(10'(last_chan), 10'(order[i]));
        end
        gaps(16, RC / 16);
        wr(8'h55, 8'h40);
        sync();
        // With averaging off every single conversion commits, so each gap is slot plus two.
        repeat (3) gaps(1, VC);
        wr(8'h73, 8'h40);
        sync();
        gaps(16, VC);
        $display("test single channel done");
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk_ctl({9'h000, adc.bypass}, 10'h000);
        foreach (rst_addr[i]) rd_chk(rst_addr[i], 8'h00);
        $display("test reset done");
        summarize();
    end
endmodule : testbench
